// >>> pkg/fixture_pkg.sv
// Constants and carrier types for the bus test fixture monitor
`default_nettype none
package fixture_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 40;
  // Restart pulse length on the host reset line
  localparam int unsigned RESTART_PULSE_NS = 1000;
  localparam int unsigned RESTART_CYCLES   =
    (RESTART_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W        = 6;

  // Fixture RAM overlay, 32 bytes at the top of memory
  localparam logic [15:0] RAM_BASE      = 16'hFFE0;
  localparam int unsigned RAM_DEPTH     = 32;
  localparam int unsigned RAM_IDX_W     = 5;
  // Restart vector location fetched after a host reset
  localparam logic [15:0] RESTART_VEC   = 16'hFFFE;
  // Fixture PROM overlay window
  localparam logic [15:0] PROM_BASE     = 16'h9000;
  localparam logic [15:0] PROM_MASK     = 16'hFF00;

  // Reset values of the fixture state
  localparam logic [15:0] ADDR_LED_RST  = 16'h0000;
  localparam logic [7:0]  DATA_LED_RST  = 8'h00;
  localparam logic [7:0]  RAM_RST       = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXAM = 2'b01,
    ST_DEP  = 2'b10
  } fix_state_t;

  // Observed host bus; data is the resolved bus level
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
    logic        vma;
    logic        opfetch;
    logic        ifetch;
    logic        ba;
  } host_bus_t;

  // Front panel; push controls are one-cycle pulses
  typedef struct packed {
    logic [7:0]  data_entry_switches;
    logic [15:0] address_entry_switches;
    logic        stop;
    logic        start;
    logic        step;
    logic        examine;
    logic        deposit;
    logic        restart;
    logic        latch_data;
    logic        latch_addr;
    logic        prom_en;
    logic        ram_en;
    logic        data_break;
    logic        addr_break;
    logic        opcode_capture_select;
  } panel_t;

  // What the fixture drives onto the host bus
  typedef struct packed {
    logic [15:0] addr;
    logic        addr_oe;
    logic [7:0]  data;
    logic        data_oe;
    logic        rw;
    logic        vma;
  } fixture_drive_t;

endpackage : fixture_pkg
`default_nettype wire

// >>> core/bus_test_fixture_monitor.sv
// Front-panel bus test fixture: run control, examine/deposit, latches, breaks, overlays
`default_nettype none
module bus_test_fixture_monitor
  import fixture_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire host_bus_t      host_bus,
  input  wire panel_t         panel,
  output fixture_drive_t      fix_drive,
  output logic                run_halt_n,
  output logic                host_reset_n,
  output logic                host_rom_block_line,
  output logic                host_mem_block_n,
  output logic                bus_free_indicator,
  output logic [15:0]         address_leds,
  output logic [7:0]          data_leds
);

  typedef struct packed {
    fix_state_t                  fsm;
    logic                        run;
    logic                        step_arm;
    logic [RST_CNT_W-1:0]        rst_cnt;
    logic [15:0]                 op_addr;
    logic [7:0]                  op_data;
    logic [15:0]                 addr_led;
    logic [7:0]                  data_led;
    logic                        bus_free;
    logic                        rom_block;
    logic [RAM_DEPTH-1:0][7:0]   ram;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= RAM_BASE);
  endfunction : in_ram

  function automatic logic in_prom(input logic [15:0] a);
    in_prom = ((a & PROM_MASK) == PROM_BASE);
  endfunction : in_prom

  // Small fixed PROM image: a branch-to-self loop
  function automatic logic [7:0] prom_byte(input logic [15:0] a);
    prom_byte = a[0] ? 8'hFE : 8'h20;
  endfunction : prom_byte

  logic        fix_cyc;
  logic        host_cyc;
  logic        cyc_valid;
  logic [15:0] cyc_addr;
  logic        cyc_rw;
  logic [7:0]  cyc_data;
  logic        ram_hit;
  logic        prom_hit;
  logic        overlay_read;
  logic        halted;
  logic        addr_match;
  logic        data_match_wr;

  always_comb begin
    fix_cyc       = (s_q.fsm == ST_EXAM) || (s_q.fsm == ST_DEP);
    host_cyc      = host_bus.vma && !host_bus.ba;
    cyc_valid     = fix_cyc || host_cyc;
    cyc_addr      = fix_cyc ? s_q.op_addr : host_bus.addr;
    cyc_rw        = fix_cyc ? (s_q.fsm == ST_EXAM) : host_bus.rw;
    cyc_data      = (s_q.fsm == ST_DEP) ? s_q.op_data : host_bus.data;
    ram_hit       = panel.ram_en && in_ram(cyc_addr);
    prom_hit      = panel.prom_en && in_prom(cyc_addr);
    overlay_read  = cyc_valid && cyc_rw && (ram_hit || prom_hit);
    halted        = host_bus.ba && !s_q.run;
    addr_match    = host_cyc && (host_bus.addr == panel.address_entry_switches);
    data_match_wr = host_cyc && !host_bus.rw && (host_bus.data == panel.data_entry_switches);
  end

  always_comb begin
    s_d = s_q;
    s_d.bus_free  = host_bus.ba;
    s_d.rom_block = panel.prom_en;

    // Run control; breaks win over start in the same cycle
    if (panel.start) begin
      s_d.run      = 1'b1;
      s_d.step_arm = 1'b0;
    end
    if (panel.step && !s_q.run) begin
      s_d.run      = 1'b1;
      s_d.step_arm = 1'b1;
    end
    // Halt line drops during the stepped instruction so it halts at its end
    if (s_q.step_arm && host_cyc && host_bus.opfetch) begin
      s_d.run      = 1'b0;
      s_d.step_arm = 1'b0;
    end
    if (panel.data_break && data_match_wr) begin
      s_d.run = 1'b0;
    end
    if (panel.addr_break && addr_match) begin
      s_d.run = 1'b0;
    end
    if (panel.stop) begin
      s_d.run      = 1'b0;
      s_d.step_arm = 1'b0;
    end

    // Restart pulse
    if (panel.restart) begin
      s_d.rst_cnt = RST_CNT_W'(RESTART_CYCLES);
    end else if (s_q.rst_cnt != '0) begin
      s_d.rst_cnt = s_q.rst_cnt - 1'b1;
    end

    // Overlay RAM writes from host or deposit
    if (cyc_valid && !cyc_rw && ram_hit) begin
      s_d.ram[cyc_addr[RAM_IDX_W-1:0]] = cyc_data;
    end

    // Indicator latches, hold otherwise
    if (host_cyc) begin
      if (panel.latch_data) begin
        if (addr_match) begin
          s_d.data_led = host_bus.data;
        end
      end else if (panel.opcode_capture_select ? host_bus.opfetch : host_bus.ifetch) begin
        s_d.data_led = host_bus.data;
      end
      if (panel.latch_addr) begin
        if (data_match_wr) begin
          s_d.addr_led = host_bus.addr;
        end
      end else if (panel.opcode_capture_select ? host_bus.opfetch : host_bus.ifetch) begin
        s_d.addr_led = host_bus.addr;
      end
    end

    // Examine / deposit sequencer, one bus cycle each
    unique case (s_q.fsm)
      ST_IDLE: begin
        if (halted && panel.examine) begin
          s_d.fsm     = ST_EXAM;
          s_d.op_addr = panel.address_entry_switches;
        end else if (halted && panel.deposit) begin
          s_d.fsm     = ST_DEP;
          s_d.op_addr = panel.address_entry_switches;
          s_d.op_data = panel.data_entry_switches;
        end
      end
      ST_EXAM: begin
        s_d.data_led = host_bus.data;
        s_d.fsm      = ST_IDLE;
      end
      ST_DEP: begin
        s_d.fsm = ST_IDLE;
      end
      default: begin
        s_d.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q.fsm       <= ST_IDLE;
      s_q.run       <= 1'b1;
      s_q.step_arm  <= 1'b0;
      s_q.rst_cnt   <= '0;
      s_q.op_addr   <= ADDR_LED_RST;
      s_q.op_data   <= DATA_LED_RST;
      s_q.addr_led  <= ADDR_LED_RST;
      s_q.data_led  <= DATA_LED_RST;
      s_q.bus_free  <= 1'b0;
      s_q.rom_block <= 1'b0;
      s_q.ram       <= {RAM_DEPTH{RAM_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus drive: own cycles from flops, overlay answers decoded per cycle
  always_comb begin
    fix_drive.addr    = s_q.op_addr;
    fix_drive.addr_oe = fix_cyc;
    fix_drive.rw      = (s_q.fsm != ST_DEP);
    fix_drive.vma     = fix_cyc;
    fix_drive.data_oe = (s_q.fsm == ST_DEP) || overlay_read;
    if (s_q.fsm == ST_DEP) begin
      fix_drive.data = s_q.op_data;
    end else if (ram_hit) begin
      fix_drive.data = s_q.ram[cyc_addr[RAM_IDX_W-1:0]];
    end else if (prom_hit) begin
      fix_drive.data = prom_byte(cyc_addr);
    end else begin
      fix_drive.data = 8'h00;
    end
  end

  assign run_halt_n          = s_q.run;
  assign host_reset_n        = (s_q.rst_cnt == '0);
  assign host_rom_block_line = !s_q.rom_block;
  assign host_mem_block_n    = !(cyc_valid && ram_hit);
  assign bus_free_indicator  = s_q.bus_free;
  assign address_leds        = s_q.addr_led;
  assign data_leds           = s_q.data_led;

  a_stop_halts: assert property (@(posedge clk) disable iff (reset)
    panel.stop |=> !run_halt_n) else $error("stop did not drop run/halt");

  a_start_runs: assert property (@(posedge clk) disable iff (reset)
    panel.start && !panel.stop && !(panel.data_break && data_match_wr) && !(panel.addr_break && addr_match)
    && !(s_q.step_arm && host_cyc && host_bus.opfetch)
    |=> run_halt_n) else $error("start did not release run/halt");

  a_step_once: assert property (@(posedge clk) disable iff (reset)
    s_q.step_arm && host_cyc && host_bus.opfetch && !panel.start |=> !run_halt_n && !s_q.step_arm)
    else $error("step did not halt after one opcode");

  a_bus_free: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> bus_free_indicator == $past(host_bus.ba)) else $error("bus-free light wrong");

  a_examine_seq: assert property (@(posedge clk) disable iff (reset)
    s_q.fsm == ST_IDLE && halted && panel.examine |=> fix_drive.addr_oe && fix_drive.rw
    && fix_drive.addr == $past(panel.address_entry_switches) ##1 !fix_drive.addr_oe)
    else $error("examine cycle malformed");

  a_deposit_seq: assert property (@(posedge clk) disable iff (reset)
    s_q.fsm == ST_IDLE && halted && !panel.examine && panel.deposit |=> fix_drive.data_oe && !fix_drive.rw
    && fix_drive.data == $past(panel.data_entry_switches)) else $error("deposit cycle malformed");

  a_restart_len: assert property (@(posedge clk) disable iff (reset)
    panel.restart ##1 !panel.restart [*8] |-> !host_reset_n) else $error("restart pulse too short");

  a_addr_latch: assert property (@(posedge clk) disable iff (reset)
    panel.latch_addr && data_match_wr |=> address_leds == $past(host_bus.addr))
    else $error("write address not latched");

  a_data_break: assert property (@(posedge clk) disable iff (reset)
    panel.data_break && data_match_wr |=> !run_halt_n) else $error("data break did not halt");

  a_addr_break: assert property (@(posedge clk) disable iff (reset)
    panel.addr_break && addr_match |=> !run_halt_n) else $error("address break did not halt");

  a_ram_overlay: assert property (@(posedge clk) disable iff (reset)
    host_cyc && host_bus.rw && panel.ram_en && host_bus.addr >= RAM_BASE |-> fix_drive.data_oe
    && !host_mem_block_n) else $error("RAM overlay did not answer");

  a_leds_hold: assert property (@(posedge clk) disable iff (reset)
    !host_cyc && s_q.fsm != ST_EXAM |=> $stable(data_leds) && $stable(address_leds))
    else $error("lights changed without a bus event");

endmodule : bus_test_fixture_monitor
`default_nettype wire

// >>> verif/host_cpu_model.sv
// Behavioural host processor and memory seen through the fixture's bus
`default_nettype none
module host_cpu_model
  import fixture_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           run_halt_n,
  input  wire logic           host_reset_n,
  input  wire logic           host_mem_block_n,
  input  wire fixture_drive_t fix_drive,
  output host_bus_t           host_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [65536];
  logic [15:0] pc_q;
  logic [2:0]  ph_q;
  logic        idle_q;
  logic [15:0] cpu_a;
  // Phases: 0/1 vector fetch, 2 halted, 3 opcode, 4 operand, 5 store operand to 0040
  assign cpu_a = (ph_q < 3'd2) ? {15'h7FFF, ph_q[0]} : (ph_q == 3'd5) ? 16'h0040 : pc_q + {15'h0, ph_q == 3'd4};
  assign host_bus.addr = fix_drive.addr_oe ? fix_drive.addr : cpu_a;
  assign host_bus.vma = fix_drive.addr_oe ? fix_drive.vma : (ph_q != 3'd2);
  assign host_bus.rw = fix_drive.addr_oe ? fix_drive.rw : (ph_q != 3'd5);
  assign host_bus.ba = (ph_q == 3'd2);
  assign host_bus.opfetch = (ph_q == 3'd3);
  assign host_bus.ifetch = (ph_q == 3'd3) || (ph_q == 3'd4);
  // Released data bus toggles so a stale byte never looks valid
  assign host_bus.data = fix_drive.data_oe ? fix_drive.data : !host_bus.vma ? {8{idle_q}} :
                         !host_bus.rw ? mem[pc_q + 16'h1] : mem[host_bus.addr];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
    pc_q = 16'h0200;
    ph_q = 3'd2;
    idle_q = 1'b0;
  end
  always @(posedge clk or negedge host_reset_n) begin
    if (!host_reset_n) begin
      ph_q <= 3'd0;
    end else begin
      idle_q <= ~idle_q;
      if (host_bus.vma && !host_bus.rw && host_mem_block_n) mem[host_bus.addr] <= host_bus.data;
      if (ph_q == 3'd0) pc_q[15:8] <= host_bus.data;
      if (ph_q == 3'd1) pc_q[7:0] <= host_bus.data;
      if (ph_q == 3'd5) pc_q <= pc_q + 16'h2;
      if (ph_q == 3'd0 || ph_q == 3'd3 || ph_q == 3'd4) ph_q <= ph_q + 3'd1;
      else ph_q <= run_halt_n ? 3'd3 : 3'd2;
    end
  end
endmodule : host_cpu_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the bus test fixture monitor
`default_nettype none
module tb_top
  import fixture_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] P_STOP = 6'h20, P_START = 6'h10, P_STEP = 6'h08;
  localparam logic [5:0] P_EXAM = 6'h04, P_DEP = 6'h02, P_RST = 6'h01;
  logic           clk = 1'b0;
  logic           reset = 1'b1;
  host_bus_t      host_bus;
  panel_t         panel;
  fixture_drive_t fix_drive;
  logic           run_halt_n, host_reset_n, host_rom_block_line, host_mem_block_n, bus_free_indicator;
  logic [15:0]    address_leds;
  logic [7:0]     data_leds;
  int             error_cnt = 0;
  int             n_compared = 0;
  always #20 clk = ~clk;
  bus_test_fixture_monitor DUT (.clk(clk), .reset(reset), .host_bus(host_bus), .panel(panel),
    .fix_drive(fix_drive), .run_halt_n(run_halt_n), .host_reset_n(host_reset_n),
    .host_rom_block_line(host_rom_block_line), .host_mem_block_n(host_mem_block_n),
    .bus_free_indicator(bus_free_indicator), .address_leds(address_leds), .data_leds(data_leds));
  host_cpu_model host (.clk(clk), .run_halt_n(run_halt_n), .host_reset_n(host_reset_n),
    .host_mem_block_n(host_mem_block_n), .fix_drive(fix_drive), .host_bus(host_bus));
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic press(input logic [5:0] p);
    @(posedge clk) {panel.stop, panel.start, panel.step, panel.examine, panel.deposit, panel.restart} <= p;
    @(posedge clk) {panel.stop, panel.start, panel.step, panel.examine, panel.deposit, panel.restart} <= 6'h00;
    #1;
  endtask : press
  task automatic wait_bf(input logic v);
    for (int i = 0; i < 400 && bus_free_indicator !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (bus_free_indicator !== v) begin
      check("bus_free_indicator", 16'(bus_free_indicator), 16'(v));
      print_verdict();
    end
  endtask : wait_bf
  task automatic set_sw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    panel.address_entry_switches <= a;
    panel.data_entry_switches <= d;
  endtask : set_sw
  task automatic exam(input logic [15:0] a);
    set_sw(a, 8'h00);
    press(P_EXAM);
    @(posedge clk);
    #1;
  endtask : exam
  task automatic t_stop_mem;
    check("run_halt_n", 16'(run_halt_n), 16'h1);
    check("host_reset_n", 16'(host_reset_n), 16'h1);
    press(P_STOP);
    check("run_halt_n", 16'(run_halt_n), 16'h0);
    wait_bf(1'b1);
    check("bus_free_indicator", 16'(bus_free_indicator), 16'h1);
    set_sw(16'h0100, 8'h5A);
    press(P_DEP);
    set_sw(16'h0101, 8'hC3);
    press(P_DEP);
    exam(16'h0100);
    check("data_leds", 16'(data_leds), 16'h005A);
    exam(16'h0101);
    check("data_leds", 16'(data_leds), 16'h00C3);
    exam(16'h0123);
    check("data_leds", 16'(data_leds), 16'h0023);
  endtask : t_stop_mem
  task automatic t_restart_step;
    int n;
    set_sw(16'hFFFE, 8'h02);
    press(P_DEP);
    set_sw(16'hFFFF, 8'h34);
    press(P_DEP);
    exam(16'hFFFE);
    check("data_leds", 16'(data_leds), 16'h0002);
    press(P_RST);
    for (n = 0; n < 100 && host_reset_n === 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check("restart_len", 16'(n), 16'(RESTART_CYCLES));
    wait_bf(1'b1);
    @(posedge clk) panel.opcode_capture_select <= 1'b1;
    press(P_STEP);
    wait_bf(1'b0);
    wait_bf(1'b1);
    check("address_leds", address_leds, 16'h0234);
    check("data_leds", 16'(data_leds), 16'h0034);
    check("run_halt_n", 16'(run_halt_n), 16'h0);
    @(posedge clk) panel.opcode_capture_select <= 1'b0;
    press(P_STEP);
    wait_bf(1'b0);
    wait_bf(1'b1);
    check("address_leds", address_leds, 16'h0237);
    check("data_leds", 16'(data_leds), 16'h0037);
  endtask : t_restart_step
  task automatic t_breaks;
    set_sw(16'h0040, 8'h39);
    panel.latch_data <= 1'b1;
    panel.latch_addr <= 1'b1;
    panel.data_break <= 1'b1;
    press(P_START);
    check("run_halt_n", 16'(run_halt_n), 16'h1);
    wait_bf(1'b0);
    wait_bf(1'b1);
    check("run_halt_n", 16'(run_halt_n), 16'h0);
    check("address_leds", address_leds, 16'h0040);
    // One more instruction runs after the break and stores 3B to the watched address
    check("data_leds", 16'(data_leds), 16'h003B);
    repeat (8) @(posedge clk);
    #1;
    check("address_leds", address_leds, 16'h0040);
    set_sw(16'h023C, 8'h00);
    panel.latch_data <= 1'b0;
    panel.latch_addr <= 1'b0;
    panel.data_break <= 1'b0;
    panel.addr_break <= 1'b1;
    panel.opcode_capture_select <= 1'b1;
    press(P_START);
    wait_bf(1'b0);
    wait_bf(1'b1);
    check("address_leds", address_leds, 16'h023C);
  endtask : t_breaks
  task automatic t_prom;
    @(posedge clk) panel.prom_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("host_rom_block_line", 16'(host_rom_block_line), 16'h0);
    exam(16'h9000);
    check("data_leds", 16'(data_leds), 16'h0020);
    exam(16'h9001);
    check("data_leds", 16'(data_leds), 16'h00FE);
  endtask : t_prom
  initial begin
    panel = '0;
    panel.ram_en = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_stop_mem();
    t_restart_step();
    t_breaks();
    t_prom();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
